// ==== verilog/cable_out_regs.sv ====
// Purpose: Output-stage parameter registers with AXI4-Lite slave and slew choice
// Assumes: Single clock aclk at 10 MHz, synchronous active-low reset
// Notes:   Unmapped addresses answer SLVERR; reads of them return zero
//
// Functional notes
// - Output 0 fast-rate emphasis length, bits 12:8
// - Output 0 fast-rate emphasis power-down, bit 6
// - Output 0 fast-rate emphasis level, bits 5:0
// - Output 0 fast-rate swing, bits 13:8, reset 19h
// - Auto slew follows locked recovered-clock rate
// - Unlocked in auto mode falls back to bypass slew
// - Output 1 bypass emphasis length, bits 12:8
// - Output 1 bypass emphasis power-down, bit 6
// - Output 1 bypass emphasis level, bits 5:0
//
// Implementation choice: the AXI4-Lite interface to the registers.
`include "cable_out_consts.svh"

module cable_out_regs
  import cable_out_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Recovered-clock state
  input  wire logic              cdr_locked,
  input  wire cdr_rate_t         cdr_rate,
  // Output 0 fast-rate trims
  output logic [4:0]             out0_hs_emphasis_pulse_len,
  output logic                   out0_hs_emphasis_off,
  output logic [5:0]             out0_hs_emphasis_level,
  output logic [5:0]             out0_hs_swing_level,
  // Output 1 bypass-rate trims
  output logic [4:0]             out1_byp_emphasis_pulse_len,
  output logic                   out1_byp_emphasis_off,
  output logic [5:0]             out1_byp_emphasis_level,
  // Slew selects
  output slew_sel_t              coax_out_a_slew,
  output slew_sel_t              coax_out_b_slew
);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Write channel capture
  // ************************************************************
  logic [ADDR_W-1:0] wr_addr;
  logic              wr_addr_held;
  logic [15:0]       wr_data;
  logic [1:0]        wr_strb;
  logic              wr_data_held;
  logic              aw_take;
  logic              w_take;
  logic              wr_go;

  // Address and data are taken in either order; both stall while a response waits
  assign s_axi_awready = !wr_addr_held && !s_axi_bvalid;
  assign s_axi_wready  = !wr_data_held && !s_axi_bvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_go         = wr_addr_held && wr_data_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr_held <= 1'b0;
      wr_data_held <= 1'b0;
    end else begin
      wr_addr_held <= wr_go ? 1'b0 : (wr_addr_held || aw_take);
      wr_data_held <= wr_go ? 1'b0 : (wr_data_held || w_take);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= '0;
      wr_data <= 16'h0000;
      wr_strb <= 2'h0;
    end else begin
      if (aw_take) wr_addr <= s_axi_awaddr;
      if (w_take) begin
        wr_data <= s_axi_wdata[15:0];
        wr_strb <= s_axi_wstrb[1:0];
      end
    end
  end

  // ************************************************************
  // Write decode
  // ************************************************************
  wire sel_w_hd_emph = (wr_addr == ADDR_W'(`ADDR_HD_PREEMPH_OUT0));
  wire sel_w_swing   = (wr_addr == ADDR_W'(`ADDR_HD_SWING_OUT0));
  wire sel_w_byp     = (wr_addr == ADDR_W'(`ADDR_BYP_PREEMPH_OUT1));
  wire sel_w_slew    = (wr_addr == ADDR_W'(`ADDR_SLEW_CTRL));
  wire sel_w_status  = (wr_addr == ADDR_W'(`ADDR_SLEW_STATUS));
  wire w_mapped      = sel_w_hd_emph || sel_w_swing || sel_w_byp || sel_w_slew;
  // Status word is read-only; writes to it are accepted and dropped
  wire w_okay        = w_mapped || sel_w_status;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= w_okay ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [15:0] hd_preemph_cfg_out0;
  logic [15:0] hd_swing_cfg_out0;
  logic [15:0] bypass_preemph_cfg_out1;
  logic [15:0] slew_ctrl;

  // Fields land exactly where written; reserved bits are stored too
  cfg_word #(.WIDTH(16), .RESET_VAL(`RST_HD_PREEMPH_OUT0)) u_hd_emph (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_go && sel_w_hd_emph),
    .wr_strb (wr_strb),
    .wr_data (wr_data),
    .value   (hd_preemph_cfg_out0)
  );

  cfg_word #(.WIDTH(16), .RESET_VAL(`RST_HD_SWING_OUT0)) u_swing (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_go && sel_w_swing),
    .wr_strb (wr_strb),
    .wr_data (wr_data),
    .value   (hd_swing_cfg_out0)
  );

  cfg_word #(.WIDTH(16), .RESET_VAL(`RST_BYP_PREEMPH_OUT1)) u_byp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_go && sel_w_byp),
    .wr_strb (wr_strb),
    .wr_data (wr_data),
    .value   (bypass_preemph_cfg_out1)
  );

  cfg_word #(.WIDTH(16), .RESET_VAL(`RST_SLEW_CTRL)) u_slew (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_go && sel_w_slew),
    .wr_strb (wr_strb),
    .wr_data (wr_data),
    .value   (slew_ctrl)
  );

  // ************************************************************
  // Analog trim outputs
  // ************************************************************
  // Swing is passed unclamped; keeping it in the accurate band is software's job
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out0_hs_emphasis_pulse_len  <= 5'h08;
      out0_hs_emphasis_off        <= 1'b0;
      out0_hs_emphasis_level      <= 6'h05;
      out0_hs_swing_level         <= 6'h19;
      out1_byp_emphasis_pulse_len <= 5'h04;
      out1_byp_emphasis_off       <= 1'b0;
      out1_byp_emphasis_level     <= 6'h04;
    end else begin
      out0_hs_emphasis_pulse_len  <= hd_preemph_cfg_out0[`EMPH_LEN_MSB:`EMPH_LEN_LSB];
      out0_hs_emphasis_off        <= hd_preemph_cfg_out0[`EMPH_OFF_BIT];
      out0_hs_emphasis_level      <= hd_preemph_cfg_out0[`EMPH_LEVEL_MSB:`EMPH_LEVEL_LSB];
      out0_hs_swing_level         <= hd_swing_cfg_out0[`SWING_MSB:`SWING_LSB];
      out1_byp_emphasis_pulse_len <= bypass_preemph_cfg_out1[`EMPH_LEN_MSB:`EMPH_LEN_LSB];
      out1_byp_emphasis_off       <= bypass_preemph_cfg_out1[`EMPH_OFF_BIT];
      out1_byp_emphasis_level     <= bypass_preemph_cfg_out1[`EMPH_LEVEL_MSB:`EMPH_LEVEL_LSB];
    end
  end

  // ************************************************************
  // Slew selection per output
  // ************************************************************
  wire out0_slew_auto_select = slew_ctrl[`SLEW_AUTO0_BIT];
  wire out1_slew_auto_select = slew_ctrl[`SLEW_AUTO1_BIT];

  slew_select u_slew_a (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .auto_select (out0_slew_auto_select),
    .manual_hd   (slew_ctrl[`SLEW_MAN0_BIT]),
    .cdr_locked  (cdr_locked),
    .cdr_rate    (cdr_rate),
    .slew_sel    (coax_out_a_slew)
  );

  slew_select u_slew_b (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .auto_select (out1_slew_auto_select),
    .manual_hd   (slew_ctrl[`SLEW_MAN1_BIT]),
    .cdr_locked  (cdr_locked),
    .cdr_rate    (cdr_rate),
    .slew_sel    (coax_out_b_slew)
  );

  // ************************************************************
  // Read channel
  // ************************************************************
  wire sel_r_hd_emph = (s_axi_araddr == ADDR_W'(`ADDR_HD_PREEMPH_OUT0));
  wire sel_r_swing   = (s_axi_araddr == ADDR_W'(`ADDR_HD_SWING_OUT0));
  wire sel_r_byp     = (s_axi_araddr == ADDR_W'(`ADDR_BYP_PREEMPH_OUT1));
  wire sel_r_slew    = (s_axi_araddr == ADDR_W'(`ADDR_SLEW_CTRL));
  wire sel_r_status  = (s_axi_araddr == ADDR_W'(`ADDR_SLEW_STATUS));
  wire r_mapped      = sel_r_hd_emph || sel_r_swing || sel_r_byp || sel_r_slew || sel_r_status;
  wire ar_take       = s_axi_arvalid && s_axi_arready;

  // Live status: slew codes of both outputs and lock, for software to observe
  wire [15:0] status_word = {11'h000, cdr_locked, coax_out_b_slew, coax_out_a_slew};

  wire [15:0] rd_word = sel_r_hd_emph ? hd_preemph_cfg_out0 :
                        sel_r_swing   ? hd_swing_cfg_out0 :
                        sel_r_byp     ? bypass_preemph_cfg_out1 :
                        sel_r_slew    ? slew_ctrl :
                        sel_r_status  ? status_word : 16'h0000;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_word};
      s_axi_rresp  <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== pkg/cable_out_consts.svh ====
// Purpose: Offsets, field positions, reset values of the output parameter bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   Printed offsets are register indices; byte address is index times four
`ifndef CABLE_OUT_CONSTS_SVH
`define CABLE_OUT_CONSTS_SVH

// ************************************************************
// Register indices and byte addresses
// ************************************************************
`define IDX_HD_PREEMPH_OUT0     8'h2e
`define IDX_HD_SWING_OUT0       8'h2f
`define IDX_BYP_PREEMPH_OUT1    8'h30
`define IDX_SLEW_CTRL           8'h3c
`define IDX_SLEW_STATUS         8'h3d
`define ADDR_HD_PREEMPH_OUT0    10'h0b8
`define ADDR_HD_SWING_OUT0      10'h0bc
`define ADDR_BYP_PREEMPH_OUT1   10'h0c0
`define ADDR_SLEW_CTRL          10'h0f0
`define ADDR_SLEW_STATUS        10'h0f4

// ************************************************************
// Field positions
// ************************************************************
`define EMPH_LEN_MSB            12
`define EMPH_LEN_LSB            8
`define EMPH_OFF_BIT            6
`define EMPH_LEVEL_MSB          5
`define EMPH_LEVEL_LSB          0
`define SWING_MSB               13
`define SWING_LSB               8
`define SLEW_AUTO0_BIT          0
`define SLEW_AUTO1_BIT          1
`define SLEW_MAN0_BIT           2
`define SLEW_MAN1_BIT           3

// ************************************************************
// Reset values
// ************************************************************
`define RST_HD_PREEMPH_OUT0     16'h0805
`define RST_HD_SWING_OUT0       16'h1980
`define RST_BYP_PREEMPH_OUT1    16'h0404
`define RST_SLEW_CTRL           16'h0003

`endif

// ==== pkg/cable_out_pkg.sv ====
// Purpose: Types shared by the output parameter bank
// Assumes: Nothing beyond the constants header
// Notes:   Slew encodings are the codes driven to the analog slew select
package cable_out_pkg;
  typedef enum logic [1:0] {
    SLEW_BYPASS = 2'h0,
    SLEW_SD     = 2'h1,
    SLEW_HD     = 2'h2
  } slew_sel_t;

  typedef enum logic [1:0] {
    RATE_SD  = 2'h0,
    RATE_HD  = 2'h1,
    RATE_3G  = 2'h2,
    RATE_OTH = 2'h3
  } cdr_rate_t;
endpackage

// ==== verilog/slew_select.sv ====
// Purpose: Choose one output's slew setting from mode and recovered-clock lock
// Assumes: Lock and rate inputs are synchronous to aclk
// Notes:   Registered so the analog select never glitches on rate changes
`include "cable_out_consts.svh"

module slew_select
  import cable_out_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Control
  input  wire logic      auto_select,
  input  wire logic      manual_hd,
  // Clock recovery state
  input  wire logic      cdr_locked,
  input  wire cdr_rate_t cdr_rate,
  // Result
  output slew_sel_t      slew_sel
);

  slew_sel_t locked_slew;
  slew_sel_t next_slew;

  assign locked_slew = (cdr_rate == RATE_SD) ? SLEW_SD :
                       (cdr_rate == RATE_OTH) ? SLEW_BYPASS : SLEW_HD;
  assign next_slew   = !auto_select ? (manual_hd ? SLEW_HD : SLEW_SD) :
                       cdr_locked ? locked_slew
                                  : SLEW_BYPASS;

  always_ff @(posedge aclk) begin
    if (!aresetn) slew_sel <= SLEW_BYPASS;
    else          slew_sel <= next_slew;
  end

endmodule

// ==== verilog/cfg_word.sv ====
// Purpose: One 16-bit read/write configuration word with byte strobes
// Assumes: Write enable is a single-cycle pulse from the bus slave
// Notes:   Every bit, reserved or not, keeps what was written
module cfg_word #(
  parameter int           WIDTH    = 16,
  parameter logic [15:0]  RESET_VAL = 16'h0000
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [1:0]       wr_strb,
  input  wire logic [WIDTH-1:0] wr_data,
  // Stored value
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] next_value;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      assign next_value[b] = (wr_en && wr_strb[b/8]) ? wr_data[b] : value[b];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) value <= RESET_VAL[WIDTH-1:0];
    else          value <= next_value;
  end

endmodule

// ==== test/cable_out_regs_checker.sv ====
// Purpose: Port-level assertions for the output parameter bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the ports of cable_out_regs
module cable_out_regs_checker
  import cable_out_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Trims
  input wire logic [4:0]  out0_hs_emphasis_pulse_len,
  input wire logic        out0_hs_emphasis_off,
  input wire logic [5:0]  out0_hs_emphasis_level,
  input wire logic [5:0]  out0_hs_swing_level,
  input wire logic [4:0]  out1_byp_emphasis_pulse_len,
  input wire logic        out1_byp_emphasis_off,
  input wire logic [5:0]  out1_byp_emphasis_level
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ************************************************************
  // Bus protocol
  // ************************************************************
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read data not zero");

  // ************************************************************
  // Trim outputs
  // ************************************************************
  chk_reset_trims: assert property ($rose(aresetn) |->
    {out0_hs_emphasis_pulse_len, out0_hs_emphasis_off, out0_hs_emphasis_level} == 12'h405
    && out0_hs_swing_level == 6'h19
    && {out1_byp_emphasis_pulse_len, out1_byp_emphasis_off, out1_byp_emphasis_level} == 12'h204)
    else $error("trims not at reset values");
  chk_trims_quiet: assert property (!$rose(s_axi_bvalid) |=> $stable({
    out0_hs_emphasis_pulse_len, out0_hs_emphasis_off, out0_hs_emphasis_level, out0_hs_swing_level,
    out1_byp_emphasis_pulse_len, out1_byp_emphasis_off, out1_byp_emphasis_level}))
    else $error("trim changed without a write");
endmodule

bind cable_out_regs cable_out_regs_checker chk_i (.*);

// ==== test/cable_out_regs_tb_top.sv ====
// Purpose: Self-checking bench for the output parameter bank
// Assumes: Bus and lock inputs driven on the rising edge
// Notes:   Protection inputs tied low; the block ignores them
`include "cable_out_consts.svh"

module cable_out_regs_tb_top
  import cable_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk = 1'h0, aresetn = 1'h0, cdr_locked = 1'h0;
  logic [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  cdr_rate_t   cdr_rate = RATE_SD;
  logic [4:0]  out0_hs_emphasis_pulse_len, out1_byp_emphasis_pulse_len;
  logic        out0_hs_emphasis_off, out1_byp_emphasis_off;
  logic [5:0]  out0_hs_emphasis_level, out0_hs_swing_level, out1_byp_emphasis_level;
  slew_sel_t   coax_out_a_slew, coax_out_b_slew;
  int          n_mismatch = 0, check_count = 0;

  cable_out_regs dut (.*);

  always #50 aclk = ~aclk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [9:0] a, input logic [15:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    check("bresp", er, s_axi_bresp);
  endtask

  task automatic read_check(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    check("rdata", exp, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
  endtask

  // Register images with reserved bits masked out
  task automatic trims_check(input logic [15:0] p0, sw, p1);
    @(negedge aclk);
    check("out0 emphasis", p0 & 16'h1f7f, {out0_hs_emphasis_pulse_len, 1'h0,
          out0_hs_emphasis_off, out0_hs_emphasis_level});
    check("out0 swing", sw[13:8], out0_hs_swing_level);
    check("out1 emphasis", p1 & 16'h1f7f, {out1_byp_emphasis_pulse_len, 1'h0,
          out1_byp_emphasis_off, out1_byp_emphasis_level});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic test_reset();
    read_check(`ADDR_HD_PREEMPH_OUT0, 32'h0805, 2'h0);
    read_check(`ADDR_HD_SWING_OUT0, 32'h1980, 2'h0);
    read_check(`ADDR_BYP_PREEMPH_OUT1, 32'h0404, 2'h0);
    trims_check(16'h0805, 16'h1980, 16'h0404);
  endtask

  // Reserved bits kept at their reset values; swing kept in the accurate band
  task automatic test_fields();
    logic [15:0] v[3] = '{16'h0a03, 16'h0000, 16'h0f4f};
    logic [15:0] s[3] = '{16'h1680, 16'h1c80, 16'h1980};
    for (int i = 0; i < 3; i++) begin
      axi_write(`ADDR_HD_PREEMPH_OUT0, v[i], 4'hf, 2'h0);
      axi_write(`ADDR_HD_SWING_OUT0, s[i], 4'hf, 2'h0);
      axi_write(`ADDR_BYP_PREEMPH_OUT1, v[i], 4'hf, 2'h0);
      read_check(`ADDR_HD_PREEMPH_OUT0, v[i], 2'h0);
      read_check(`ADDR_HD_SWING_OUT0, s[i], 2'h0);
      read_check(`ADDR_BYP_PREEMPH_OUT1, v[i], 2'h0);
      trims_check(v[i], s[i], v[i]);
    end
  endtask

  // Upper strobes fall outside the 16-bit word
  task automatic test_strobe();
    axi_write(`ADDR_HD_PREEMPH_OUT0, 16'h1234, 4'hd, 2'h0);
    read_check(`ADDR_HD_PREEMPH_OUT0, 32'h0f34, 2'h0);
    axi_write(`ADDR_HD_SWING_OUT0, 16'h1234, 4'he, 2'h0);
    read_check(`ADDR_HD_SWING_OUT0, 32'h1280, 2'h0);
    axi_write(10'h004, 16'hffff, 4'hf, 2'h2);
    read_check(10'h004, 32'h0, 2'h2);
  endtask

  task automatic test_slew();
    slew_sel_t e[5] = '{SLEW_SD, SLEW_HD, SLEW_HD, SLEW_BYPASS, SLEW_BYPASS};
    axi_write(`ADDR_SLEW_CTRL, 16'h0003, 4'hf, 2'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      cdr_locked <= (i < 4);
      cdr_rate <= cdr_rate_t'(i[1:0]);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      check("slew", {e[i], e[i]}, {coax_out_a_slew, coax_out_b_slew});
    end
    read_check(`ADDR_SLEW_STATUS, 32'h0, 2'h0);
    axi_write(`ADDR_SLEW_CTRL, 16'h0004, 4'hf, 2'h0);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check("manual slew", {SLEW_HD, SLEW_SD}, {coax_out_a_slew, coax_out_b_slew});
    read_check(`ADDR_SLEW_STATUS, 32'h0006, 2'h0);
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    test_reset();
    test_fields();
    test_strobe();
    test_slew();
    // Mid-run reset must restore every emphasis and swing field
    @(posedge aclk);
    aresetn <= 1'h0;
    @(posedge aclk);
    aresetn <= 1'h1;
    test_reset();
    complete_run();
  end
endmodule
